// ### verilog/flash_onboard_prog_entry.sv
// on-board programming entry: strap decode, serial boot loader, emulation overlay
// Operation
// - overlay register resets zero, survives standby
// - overlay bits 15 to 3 read zero
// - emulation select blocks all program/erase
// - emulation select ignored with rom disabled
// - area bits pick overlaid 1 kB block
// - programming strap at reset enables programming
// - decode chip mode, boot/user, clock multiple
// - boot loads program over serial into ram
// - branch to program start after download
// - measure zero-byte low period for rate
// - 8 data bits, 1 stop, no parity
// - send one zero byte after rate found
// - boot ram area locked until branch
// - control program runs outside flash
module flash_onboard_prog_entry
  import flash_prog_pkg::*;
(
  input  wire logic                  clk_in,
  input  wire logic                  rstn_in,
  input  wire logic [1:0]            avs_address_in,
  input  wire logic                  avs_read_in,
  input  wire logic                  avs_write_in,
  input  wire logic [31:0]           avs_writedata_in,
  output logic [31:0]                avs_readdata_out,
  output logic                       avs_waitrequest_out,
  input  wire logic                  flash_write_protect_pin_in,
  input  wire logic                  mode_pin_3_in,
  input  wire logic                  mode_pin_2_in,
  input  wire logic                  mode_pin_1_in,
  input  wire logic                  mode_pin_0_in,
  input  wire logic                  rom_enable_in,
  input  wire logic                  serial_rx_in,
  output logic                       serial_tx_out,
  output flash_prog_pkg::mode_s      mode_out,
  output logic                       prog_state_out,
  output logic                       ram_wr_out,
  output logic [15:0]                ram_addr_out,
  output logic [7:0]                 ram_wdata_out,
  output logic                       boot_area_lock_out,
  output logic                       branch_out,
  output logic [23:0]                branch_addr_out,
  output logic                       overlay_en_out,
  output logic [23:0]                overlay_base_out,
  output logic                       flash_pe_block_out
);
  import flash_prog_pkg::*;

  // pin synchronisers: rx, fwp, mode[3:0], rom enable
  logic [6:0] pin_meta_q;
  logic [6:0] pin_sync_q;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pin_meta_q <= 7'h7f;
      pin_sync_q <= 7'h7f;
    end else begin
      pin_meta_q <= {rom_enable_in, mode_pin_3_in, mode_pin_2_in, mode_pin_1_in,
                     mode_pin_0_in, flash_write_protect_pin_in, serial_rx_in};
      pin_sync_q <= pin_meta_q;
    end
  end
  logic       rx_s;
  logic       fwp_s;
  logic [3:0] mode_s_pins;
  logic       rom_en_s;
  assign rx_s        = pin_sync_q[0];
  assign fwp_s       = pin_sync_q[1];
  assign mode_s_pins = pin_sync_q[5:2];
  assign rom_en_s    = pin_sync_q[6];

  // boot sequencer state
  boot_state_e state_q, state_d;
  mode_s       mode_q, mode_d;
  logic [1:0]  wait_cnt_q, wait_cnt_d;
  logic [15:0] len_q, len_d;
  logic [15:0] idx_q, idx_d;
  logic        ram_wr_q, ram_wr_d;
  logic [15:0] ram_addr_q, ram_addr_d;
  logic [7:0]  ram_wdata_q, ram_wdata_d;
  logic        lock_q, lock_d;
  logic        branch_q, branch_d;
  logic [23:0] branch_addr_q, branch_addr_d;
  logic        meas_start;
  logic        tx_start;
  logic [15:0] div_q, div_d;

  logic        meas_done;
  logic [15:0] meas_cycles;
  logic        tx_busy;
  logic        rx_valid;
  logic [7:0]  rx_byte;

  baud_measure u_baud (
    .clk_in         (clk_in),
    .rstn_in        (rstn_in),
    .start_in       (meas_start),
    .rx_in          (rx_s),
    .done_out       (meas_done),
    .bit_cycles_out (meas_cycles)
  );

  serial_byte_io u_sio (
    .clk_in       (clk_in),
    .rstn_in      (rstn_in),
    .div_in       (div_q),
    .tx_start_in  (tx_start),
    .tx_byte_in   (ACK_BYTE),
    .tx_busy_out  (tx_busy),
    .tx_out       (serial_tx_out),
    .rx_en_in     (state_q != ST_MEASURE && state_q != ST_ACK_TX),
    .rx_in        (rx_s),
    .rx_valid_out (rx_valid),
    .rx_byte_out  (rx_byte)
  );

  always_comb begin
    state_d       = state_q;
    mode_d        = mode_q;
    wait_cnt_d    = wait_cnt_q;
    len_d         = len_q;
    idx_d         = idx_q;
    ram_wr_d      = 1'b0;
    ram_addr_d    = ram_addr_q;
    ram_wdata_d   = ram_wdata_q;
    lock_d        = lock_q;
    branch_d      = 1'b0;
    branch_addr_d = branch_addr_q;
    div_d         = div_q;
    meas_start    = 1'b0;
    tx_start      = 1'b0;
    case (state_q)
      ST_STRAP: begin
        wait_cnt_d = wait_cnt_q + 2'h1;
        if (wait_cnt_q == STRAP_WAIT) begin
          mode_d.single_chip = mode_s_pins[0];
          mode_d.user_prog   = mode_s_pins[1];
          mode_d.clk_mult    = mode_s_pins[3:2];
          mode_d.valid = !fwp_s && (mode_s_pins[3:2] != 2'h3);
          if (!mode_d.valid || mode_s_pins[1]) begin
            state_d = ST_USER;
          end else begin
            lock_d     = 1'b1;
            meas_start = 1'b1;
            state_d    = ST_MEASURE;
          end
        end
      end
      ST_MEASURE: begin
        if (meas_done) begin
          div_d   = meas_cycles;
          state_d = ST_ACK_TX;
        end
      end
      ST_ACK_TX: begin
        if (!tx_busy && !rx_s) begin
          state_d = ST_ACK_TX;
        end else if (!tx_busy) begin
          tx_start = 1'b1;
          state_d  = ST_WAIT_SYNC;
        end
      end
      ST_WAIT_SYNC: if (rx_valid && rx_byte == SYNC_BYTE) state_d = ST_LEN_HI;
      ST_LEN_HI: begin
        if (rx_valid) begin
          len_d[15:8] = rx_byte;
          state_d     = ST_LEN_LO;
        end
      end
      ST_LEN_LO: begin
        if (rx_valid) begin
          len_d[7:0] = rx_byte;
          idx_d      = 16'h0000;
          state_d    = ({len_q[15:8], rx_byte} == 16'h0000) ? ST_BRANCH : ST_LOAD;
        end
      end
      // store program bytes into ram area
      ST_LOAD: begin
        if (rx_valid) begin
          ram_wr_d    = 1'b1;
          ram_addr_d  = PROG_AREA_BASE + idx_q;
          ram_wdata_d = rx_byte;
          idx_d       = idx_q + 16'h0001;
          if (idx_q == len_q - 16'h0001) state_d = ST_BRANCH;
        end
      end
      ST_BRANCH: begin
        branch_d      = 1'b1;
        branch_addr_d = PROG_START_ADDR;
        lock_d        = 1'b0;
        state_d       = ST_RUN;
      end
      ST_RUN:  state_d = ST_RUN;
      ST_USER: state_d = ST_USER;
      default: state_d = ST_STRAP;
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q       <= ST_STRAP;
      mode_q        <= '0;
      wait_cnt_q    <= 2'h0;
      len_q         <= 16'h0000;
      idx_q         <= 16'h0000;
      ram_wr_q      <= 1'b0;
      ram_addr_q    <= 16'h0000;
      ram_wdata_q   <= 8'h00;
      lock_q        <= 1'b0;
      branch_q      <= 1'b0;
      branch_addr_q <= 24'h000000;
      div_q         <= 16'h0001;
    end else begin
      state_q       <= state_d;
      mode_q        <= mode_d;
      wait_cnt_q    <= wait_cnt_d;
      len_q         <= len_d;
      idx_q         <= idx_d;
      ram_wr_q      <= ram_wr_d;
      ram_addr_q    <= ram_addr_d;
      ram_wdata_q   <= ram_wdata_d;
      lock_q        <= lock_d;
      branch_q      <= branch_d;
      branch_addr_q <= branch_addr_d;
      div_q         <= div_d;
    end
  end

  // register slave and overlay
  logic [15:0] ovl_q, ovl_d;
  logic        wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic        ovl_en_q, ovl_en_d;
  logic [23:0] ovl_base_q, ovl_base_d;
  logic        pe_block_q, pe_block_d;
  logic        req;
  assign req = avs_read_in || avs_write_in;

  always_comb begin
    ovl_d   = ovl_q;
    rdata_d = rdata_q;
    // one wait cycle, then answer for one cycle
    wait_d  = !(req && wait_q);
    if (req && wait_q) begin
      case (avs_address_in)
        REG_OVERLAY: rdata_d = {16'h0000, ovl_q & OVL_WRITE_MASK};
        REG_STATUS:  rdata_d = {16'h0000, 6'h00, lock_q, (state_q == ST_RUN),
                                3'h0, mode_q};
        REG_BAUD:    rdata_d = {16'h0000, div_q};
        default:     rdata_d = 32'h0000_0000;
      endcase
    end
    if (avs_write_in && !wait_q && avs_address_in == REG_OVERLAY) begin
      ovl_d = avs_writedata_in[15:0] & OVL_WRITE_MASK;
    end
    ovl_en_d   = ovl_q[OVL_SEL_BIT] && rom_en_s;
    pe_block_d = ovl_q[OVL_SEL_BIT] && rom_en_s;
    ovl_base_d = ovl_en_d ? (EMU_BLOCK_BASE | ({22'h000000, ovl_q[1:0]} << EMU_STEP_SHIFT))
                          : RAM_WINDOW_BASE;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      // power-on clear only, standby keeps it
      ovl_q      <= OVL_RESET;
      wait_q     <= 1'b1;
      rdata_q    <= 32'h0000_0000;
      ovl_en_q   <= 1'b0;
      ovl_base_q <= RAM_WINDOW_BASE;
      pe_block_q <= 1'b0;
    end else begin
      ovl_q      <= ovl_d;
      wait_q     <= wait_d;
      rdata_q    <= rdata_d;
      ovl_en_q   <= ovl_en_d;
      ovl_base_q <= ovl_base_d;
      pe_block_q <= pe_block_d;
    end
  end

  assign avs_readdata_out    = rdata_q;
  assign avs_waitrequest_out = wait_q;
  assign mode_out            = mode_q;
  assign prog_state_out      = mode_q.valid;
  assign ram_wr_out          = ram_wr_q;
  assign ram_addr_out        = ram_addr_q;
  assign ram_wdata_out       = ram_wdata_q;
  assign boot_area_lock_out  = lock_q;
  assign branch_out          = branch_q;
  assign branch_addr_out     = branch_addr_q;
  assign overlay_en_out      = ovl_en_q;
  assign overlay_base_out    = ovl_base_q;
  assign flash_pe_block_out  = pe_block_q;

  ovl_read_zero_a:
    assert property (@(posedge clk_in) disable iff (!rstn_in)
      avs_read_in && !avs_waitrequest_out && avs_address_in == REG_OVERLAY
      |-> avs_readdata_out[31:3] == 29'h0)
    else $error("overlay reserved bits read nonzero");
  ovl_write_a:
    assert property (@(posedge clk_in) disable iff (!rstn_in)
      avs_write_in && !avs_waitrequest_out && avs_address_in == REG_OVERLAY
      |=> ovl_q == {13'h0, $past(avs_writedata_in[2:0])})
    else $error("overlay write not stored as three low bits");
  pe_block_a:
    assert property (@(posedge clk_in) disable iff (!rstn_in)
      ovl_q[OVL_SEL_BIT] && rom_en_s |=> flash_pe_block_out)
    else $error("program/erase not blocked under emulation");
  rom_ignore_a:
    assert property (@(posedge clk_in) disable iff (!rstn_in)
      !rom_en_s |=> !overlay_en_out && !flash_pe_block_out)
    else $error("emulation select honoured with rom disabled");
  overlay_map_a:
    assert property (@(posedge clk_in) disable iff (!rstn_in)
      ##1 overlay_en_out |-> overlay_base_out[23:12] == 12'h03f
      && overlay_base_out[11:10] == $past(ovl_q[1:0]))
    else $error("overlay window on wrong block");
  prog_state_a:
    assert property (@(posedge clk_in) disable iff (!rstn_in)
      prog_state_out |-> mode_out.clk_mult != 2'h3)
    else $error("programming state with invalid strap");
  ack_zero_a:
    assert property (@(posedge clk_in) disable iff (!rstn_in)
      state_q == ST_ACK_TX && tx_start |=> state_q == ST_WAIT_SYNC ##1 serial_tx_out == 1'b0)
    else $error("acknowledge byte not started");
  branch_addr_a:
    assert property (@(posedge clk_in) disable iff (!rstn_in)
      branch_out |-> branch_addr_out == PROG_START_ADDR && !boot_area_lock_out)
    else $error("branch to wrong address");
  lock_release_a:
    assert property (@(posedge clk_in) disable iff (!rstn_in)
      $fell(boot_area_lock_out) |-> branch_out)
    else $error("boot area unlocked without branch");
endmodule : flash_onboard_prog_entry

// ### verilog/flash_prog_pkg.sv
// shared constants and types for the on-board programming entry block
package flash_prog_pkg;
  // register word indices on the avalon slave
  localparam logic [1:0]  REG_OVERLAY     = 2'h0;
  localparam logic [1:0]  REG_STATUS      = 2'h1;
  localparam logic [1:0]  REG_BAUD        = 2'h2;
  // overlay register layout
  localparam logic [15:0] OVL_RESET       = 16'h0000;
  localparam logic [15:0] OVL_WRITE_MASK  = 16'h0007;
  localparam int          OVL_SEL_BIT     = 2;
  // overlay address map
  localparam logic [23:0] RAM_WINDOW_BASE = 24'hfff800;
  localparam logic [23:0] EMU_BLOCK_BASE  = 24'h03f000;
  localparam int          EMU_STEP_SHIFT  = 10;
  // boot download area and branch target
  localparam logic [15:0] PROG_AREA_BASE  = 16'h0400;
  localparam logic [23:0] PROG_START_ADDR = 24'hffd400;
  // serial protocol bytes and framing
  localparam logic [7:0]  ACK_BYTE        = 8'h00;
  localparam logic [7:0]  SYNC_BYTE       = 8'h55;
  localparam logic [15:0] LOW_BIT_COUNT   = 16'h0009;
  localparam logic [3:0]  FRAME_BITS      = 4'ha;
  // cycles to let the pin synchronisers settle before strap capture
  localparam logic [1:0]  STRAP_WAIT      = 2'h3;
  // clock multiple codes
  localparam logic [1:0]  MULT_X1         = 2'h0;
  localparam logic [1:0]  MULT_X2         = 2'h1;
  localparam logic [1:0]  MULT_X4         = 2'h2;

  typedef struct packed {
    logic       valid;
    logic       user_prog;
    logic       single_chip;
    logic [1:0] clk_mult;
  } mode_s;

  typedef enum {ST_STRAP, ST_MEASURE, ST_ACK_TX, ST_WAIT_SYNC, ST_LEN_HI, ST_LEN_LO,
                ST_LOAD, ST_BRANCH, ST_RUN, ST_USER} boot_state_e;
endpackage : flash_prog_pkg

// ### verilog/baud_measure.sv
// measures the low run of a zero byte and derives the bit period
module baud_measure
  import flash_prog_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic        start_in,
  input  wire logic        rx_in,
  output logic             done_out,
  output logic [15:0]      bit_cycles_out
);
  typedef enum {B_IDLE, B_WAIT_HIGH, B_WAIT_LOW, B_COUNT, B_DIV} meas_state_e;
  meas_state_e state_q, state_d;
  logic [15:0] cnt_q, cnt_d;
  logic [15:0] quot_q, quot_d;
  logic        done_q, done_d;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    quot_d  = quot_q;
    done_d  = 1'b0;
    case (state_q)
      B_IDLE: if (start_in) state_d = B_WAIT_HIGH;
      B_WAIT_HIGH: if (rx_in) state_d = B_WAIT_LOW;
      B_WAIT_LOW: begin
        cnt_d = 16'h0000;
        if (!rx_in) state_d = B_COUNT;
      end
      // time low run of zero byte
      B_COUNT: begin
        if (rx_in) begin
          quot_d  = 16'h0000;
          state_d = B_DIV;
        end else if (cnt_q != 16'hffff) begin
          cnt_d = cnt_q + 16'h0001;
        end
      end
      // low run covers start bit plus eight zeros
      B_DIV: begin
        if (cnt_q >= LOW_BIT_COUNT) begin
          cnt_d  = cnt_q - LOW_BIT_COUNT;
          quot_d = quot_q + 16'h0001;
        end else if (quot_q == 16'h0000) begin
          state_d = B_WAIT_LOW;
        end else begin
          done_d  = 1'b1;
          state_d = B_IDLE;
        end
      end
      default: state_d = B_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q <= B_IDLE;
      cnt_q   <= 16'h0000;
      quot_q  <= 16'h0000;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      quot_q  <= quot_d;
      done_q  <= done_d;
    end
  end

  assign done_out       = done_q;
  assign bit_cycles_out = quot_q;

  rate_nonzero_a:
    assert property (@(posedge clk_in) disable iff (!rstn_in)
      done_out |-> bit_cycles_out != 16'h0000)
    else $error("measured bit period is zero");
endmodule : baud_measure

// ### verilog/serial_byte_io.sv
// 8n1 byte transmitter and receiver with a run-time bit period
module serial_byte_io
  import flash_prog_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic [15:0] div_in,
  input  wire logic        tx_start_in,
  input  wire logic [7:0]  tx_byte_in,
  output logic             tx_busy_out,
  output logic             tx_out,
  input  wire logic        rx_en_in,
  input  wire logic        rx_in,
  output logic             rx_valid_out,
  output logic [7:0]       rx_byte_out
);
  logic [9:0]  tsh_q, tsh_d;
  logic [3:0]  tbit_q, tbit_d;
  logic [15:0] tcnt_q, tcnt_d;
  logic        tx_q, tx_d;
  logic [8:0]  rsh_q, rsh_d;
  logic [3:0]  rbit_q, rbit_d;
  logic [15:0] rcnt_q, rcnt_d;
  logic        rvalid_q, rvalid_d;

  always_comb begin
    tsh_d    = tsh_q;
    tbit_d   = tbit_q;
    tcnt_d   = tcnt_q;
    tx_d     = tx_q;
    rsh_d    = rsh_q;
    rbit_d   = rbit_q;
    rcnt_d   = rcnt_q;
    rvalid_d = 1'b0;
    if (tbit_q == 4'h0) begin
      tx_d = 1'b1;
      if (tx_start_in) begin
        tsh_d  = {1'b1, tx_byte_in, 1'b0};
        tbit_d = FRAME_BITS;
        tcnt_d = 16'h0000;
      end
    end else if (tcnt_q == 16'h0000) begin
      tx_d   = tsh_q[0];
      tsh_d  = {1'b1, tsh_q[9:1]};
      tcnt_d = div_in - 16'h0001;
      tbit_d = tbit_q - 4'h1;
    end else begin
      tcnt_d = tcnt_q - 16'h0001;
    end
    if (rbit_q == 4'h0) begin
      if (rx_en_in && !rx_in) begin
        rbit_d = FRAME_BITS;
        rcnt_d = {1'b0, div_in[15:1]};
      end
    end else if (rcnt_q == 16'h0000) begin
      rcnt_d = div_in - 16'h0001;
      rbit_d = rbit_q - 4'h1;
      if (rbit_q == 4'h1) begin
        // stop bit must read high, shifter keeps the data
        rvalid_d = rx_in;
      end else begin
        rsh_d = {rx_in, rsh_q[8:1]};
        if (rbit_q == FRAME_BITS && rx_in) begin
          rbit_d = 4'h0;
        end
      end
    end else begin
      rcnt_d = rcnt_q - 16'h0001;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tsh_q    <= 10'h3ff;
      tbit_q   <= 4'h0;
      tcnt_q   <= 16'h0000;
      tx_q     <= 1'b1;
      rsh_q    <= 9'h000;
      rbit_q   <= 4'h0;
      rcnt_q   <= 16'h0000;
      rvalid_q <= 1'b0;
    end else begin
      tsh_q    <= tsh_d;
      tbit_q   <= tbit_d;
      tcnt_q   <= tcnt_d;
      tx_q     <= tx_d;
      rsh_q    <= rsh_d;
      rbit_q   <= rbit_d;
      rcnt_q   <= rcnt_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign tx_busy_out  = (tbit_q != 4'h0);
  assign tx_out       = tx_q;
  assign rx_valid_out = rvalid_q;
  assign rx_byte_out  = rsh_q[8:1];
endmodule : serial_byte_io

// ### sim/host_serial_model.sv
// host side of the serial boot link, 8n1 at a fixed bit period
module host_serial_model
  import flash_prog_pkg::*;
#(
  parameter int BIT = 1042
) (
  input  wire logic        clk_in,
  input  wire logic        start_in,
  input  wire logic        tx_in,
  input  wire logic [15:0] payload_in,
  output logic             rx_out,
  output logic             done_out,
  output logic             ack_ok_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // start, 8 data lsb first, stop
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_out <= f[i];
      repeat (BIT) @(posedge clk_in);
    end
  endtask : send
  // sample mid-bit, stop must be high
  task automatic recv(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    while (tx_in !== 1'b0 && n < 40000) begin
      @(posedge clk_in);
      n++;
    end
    repeat (BIT / 2) @(posedge clk_in);
    ok = (tx_in === 1'b0);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk_in);
      b[i] = tx_in;
    end
    repeat (BIT) @(posedge clk_in);
    ok = ok && (tx_in === 1'b1);
  endtask : recv
  initial begin
    logic [7:0] a;
    logic       ok;
    rx_out = 1'b1;
    done_out = 1'b0;
    ack_ok_out = 1'b0;
    wait (start_in === 1'b1);
    fork
      send(8'h00);
      recv(a, ok);
    join
    // check ack, then sync and payload
    ack_ok_out <= ok && (a === ACK_BYTE);
    if (ok && a === ACK_BYTE) begin
      send(SYNC_BYTE);
      send(8'h00);
      send(8'h02);
      send(payload_in[15:8]);
      send(payload_in[7:0]);
    end
    done_out <= 1'b1;
  end
endmodule : host_serial_model

// ### sim/tb.sv
// self-checking bench for the on-board programming entry block
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import flash_prog_pkg::*;
  logic        clk_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic [1:0]  a_addr = '0;
  logic        a_rd = 1'b0;
  logic        a_wr = 1'b0;
  logic [31:0] a_wd = '0;
  logic [31:0] a_rdata;
  logic        a_wait;
  logic        flash_write_protect_pin = 1'b0;
  logic [3:0]  md = 4'h3;
  logic        rom_en = 1'b1;
  logic        rx;
  logic        tx;
  mode_s       mode;
  logic        pstate, ram_wr, lock, br, ovl_en, pe_blk, h_go = 1'b0, h_done, h_ok;
  logic        br_seen = 1'b0;
  logic [15:0] ram_addr, payload = '0;
  logic [7:0]  ram_wd;
  logic [23:0] br_addr, ovl_base;
  logic [31:0] rd_q[$];
  logic [23:0] ram_q[$];
  int          err_count = 0;
  int          total_checks = 0;
  always #50 clk_in = ~clk_in;
  flash_onboard_prog_entry DUT (.clk_in(clk_in), .rstn_in(rstn_in),
    .avs_address_in(a_addr), .avs_read_in(a_rd), .avs_write_in(a_wr),
    .avs_writedata_in(a_wd), .avs_readdata_out(a_rdata), .avs_waitrequest_out(a_wait),
    .flash_write_protect_pin_in(flash_write_protect_pin), .mode_pin_3_in(md[3]), .mode_pin_2_in(md[2]),
    .mode_pin_1_in(md[1]), .mode_pin_0_in(md[0]), .rom_enable_in(rom_en),
    .serial_rx_in(rx), .serial_tx_out(tx), .mode_out(mode), .prog_state_out(pstate),
    .ram_wr_out(ram_wr), .ram_addr_out(ram_addr), .ram_wdata_out(ram_wd),
    .boot_area_lock_out(lock), .branch_out(br), .branch_addr_out(br_addr),
    .overlay_en_out(ovl_en), .overlay_base_out(ovl_base), .flash_pe_block_out(pe_blk));
  host_serial_model host (.clk_in(clk_in), .start_in(h_go), .tx_in(tx),
    .payload_in(payload), .rx_out(rx), .done_out(h_done), .ack_ok_out(h_ok));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  task automatic bus(input logic w, input logic [1:0] ad, input logic [31:0] d,
                     input logic [31:0] e);
    int n;
    @(posedge clk_in);
    {a_addr, a_wd, a_wr, a_rd} <= {ad, d, w, !w};
    if (!w) rd_q.push_back(e);
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (a_wait !== 1'b0 && n < 50);
    if (n >= 50) check("bus answer", 0, 1);
    if (n >= 50) complete_run();
    {a_wr, a_rd} <= 2'b00;
  endtask : bus
  task automatic do_reset(input logic [3:0] m, input logic f);
    @(posedge clk_in);
    {rstn_in, md, flash_write_protect_pin} <= {1'b0, m, f};
    repeat (4) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (8) @(posedge clk_in);
  endtask : do_reset
  always @(posedge clk_in) begin
    if (a_rd && a_wait === 1'b0) check("readdata", rd_q.pop_front(), a_rdata);
    if (ram_wr === 1'b1) check("ram write", ram_q.pop_front(), {ram_addr, ram_wd});
    if (br === 1'b1) br_seen <= 1'b1;
  end
  initial begin
    logic [2:0]  s;
    logic        v;
    logic [23:0] b;
    int          n;
    void'($urandom(63107));
    for (int i = 0; i < 32; i++) begin
      do_reset(i[3:0], i[4]);
      v = !i[4] && i[3:2] != 2'h3;
      check("mode valid", v, mode.valid);
      check("prog state", v, pstate);
      if (v) check("mode", {1'b1, i[1], i[0], i[3:2]}, mode);
    end
    $display("test straps done");
    // overlay tested in user program mode; writes are accepted in any mode
    do_reset(4'h3, 1'b0);
    bus(1'b0, REG_OVERLAY, 0, 0);
    bus(1'b1, REG_OVERLAY, 32'hfffffff8, 0);
    bus(1'b0, REG_OVERLAY, 0, 0);
    for (int j = 0; j < 16; j++) begin
      s = j[2:0];
      rom_en <= j[3];
      bus(1'b1, REG_OVERLAY, ($urandom() & 32'hfffffff8) | s, 0);
      bus(1'b0, REG_OVERLAY, 0, {29'h0, s});
      repeat (4) @(posedge clk_in);
      v = s[2] & j[3];
      b = v ? EMU_BLOCK_BASE + {12'h0, s[1:0], 10'h0} : RAM_WINDOW_BASE;
      check("overlay en", v, ovl_en);
      check("pe block", v, pe_blk);
      check("overlay base", b, ovl_base);
    end
    bus(1'b1, 2'h3, 0, 0);
    bus(1'b0, 2'h3, 0, 0);
    bus(1'b0, REG_OVERLAY, 0, 32'h7);
    do_reset(4'h3, 1'b0);
    bus(1'b0, REG_OVERLAY, 0, 0);
    $display("test overlay done");
    do_reset(4'h1, 1'b0);
    check("lock at entry", 1, lock);
    payload <= 16'($urandom());
    @(posedge clk_in);
    ram_q.push_back({PROG_AREA_BASE, payload[15:8]});
    ram_q.push_back({PROG_AREA_BASE + 16'h1, payload[7:0]});
    h_go <= 1'b1;
    n = 0;
    while (h_done !== 1'b1 && n < 90000) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= 90000) begin
      check("host done", 0, 1);
      complete_run();
    end
    // a bad ack fails the run instead of retrying
    check("ack byte", 1, h_ok);
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (br_seen !== 1'b1 && n < 3000);
    check("branch seen", 1, br_seen);
    check("branch addr", PROG_START_ADDR, br_addr);
    check("lock after", 0, lock);
    check("bytes left", 0, ram_q.size());
    bus(1'b0, REG_STATUS, 0, 32'h0000_0114);
    @(posedge clk_in);
    $display("test boot done");
    complete_run();
  end
endmodule : tb
